// *** rtl/krs_map.vh ***
`ifndef KRS_MAP_VH
`define KRS_MAP_VH
// ************************************************************
// register offsets
// ************************************************************
`define KRS_A_CTRL 4'h0
`define KRS_A_SCOPE 4'h1
`define KRS_A_CAPC_HI 4'h2
`define KRS_A_CAPC_LO 4'h3
`define KRS_A_LADC 4'h4
`define KRS_A_NEG_GB 4'h5
`define KRS_A_POS_GB 4'h6
`define KRS_A_STATUS 4'h7
`define KRS_A_KEY_ERR 4'h8
`define KRS_A_SUPP_EN 4'h9
`define KRS_A_ERR_MAP 4'hA
`define KRS_A_REF 4'hB
// ************************************************************
// field positions
// ************************************************************
`define KRS_CTRL_RECAL 0
`define KRS_CTRL_LOCK 1
`define KRS_CTRL_SRST 2
`define KRS_SCOPE_ALL 7
`define KRS_ST_DETECT 0
`define KRS_ST_CAL 1
`define KRS_ST_ERR 2
`define KRS_ST_LOCKED 3
`define KRS_ST_SETUP 4
`define KRS_ERR_HIGH 2
`define KRS_ERR_LOW 3
// ************************************************************
// reset values
// ************************************************************
`define KRS_RST_CAPC 16'h05E9
`define KRS_RST_LADC 8'h08
`define KRS_RST_GB 8'h00
`define KRS_RST_SCOPE 8'h80
`define KRS_RST_REF 8'h80
// ************************************************************
// timing counts and limits
// ************************************************************
`define KRS_FULL_CAL_BURSTS 5'd26
`define KRS_CAL_COARSE_END 5'd14
`define KRS_BOUND_HI 8'hBF
`define KRS_BOUND_LO 8'h40
`define KRS_NEG_GB_MAX 8'h63
`define KRS_POS_GB_MAX 8'h64
`endif

// *** rtl/krs_key_reference_supervisor.v ***
// Summary of operation
// - absolute reference = cap coef * cap count + ladder coef * offset + window ref.
// - lock command computes and stores every key's absolute reference.
// - after lock, running reference beyond either guardband flags the key.
// - guardband errors appear only after the key's full recalibration.
// - guardband errors set key error bit 2 or 3 and the all-keys map.
// - guardband violation never starts a recalibration by itself.
// - enabled key suppressed if another enabled key deviates more negatively.
// - suppression spans all enabled keys, enable kept per key.
// - suppression compares raw deviations, ignoring gain and threshold.
// - full recalibration after power-up, hard reset, soft reset or command.
// - full recalibration takes 26 bursts, fast recalibration one burst.
// - keys in command scope recalibrate concurrently.
// - error bit 2 when window ref above 191, bit 3 when below 64.
// - boundary check uses window ref only and marks the all-keys map.
// - boundary error never starts a recalibration by itself.
// - calibrated reference lands near the window middle 0x80.
// - status byte summarises detecting, calibrating and error keys.
// - status bit 4 on setup/backup mismatch or uncopied setup change.
// - on reset copy valid setup to backup, otherwise restore from backup.
// - obstructed key recalibrates again via positive-threshold fast recal.
// - negative guard 1..99 percent, positive 10..1000 percent, zero off.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "krs_map.vh"
module krs_key_reference_supervisor #(
  parameter NUM_KEYS = 64,
  parameter KEY_W = 6,
  parameter CAP_W = 4
) (
  input wire ref_clk_i,
  input wire rstn_i,
  input wire [3:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire burst_done_i,
  input wire [KEY_W-1:0] burst_key_i,
  input wire [7:0] burst_signal_i,
  input wire burst_detect_i,
  input wire fast_recal_i,
  input wire [1:0] drift_step_i,
  input wire [KEY_W-1:0] scan_key_i,
  output reg [CAP_W-1:0] cancel_cap_count_o,
  output reg [7:0] ladder_offset_o,
  output reg [NUM_KEYS-1:0] key_detect_o,
  input wire setup_valid_i,
  input wire backup_differs_i,
  output reg backup_copy_o,
  output reg backup_restore_o
);

  // ************************************************************
  // functions
  // ************************************************************
  function [23:0] f_abs;
    input [15:0] c1;
    input [7:0] c2;
    input [CAP_W-1:0] n;
    input [7:0] o;
    input [7:0] r;
    begin
      f_abs = c1 * n + c2 * o + r;
    end
  endfunction

  // bit0 above positive band, bit1 below negative band
  function [1:0] f_guard;
    input [23:0] run;
    input [23:0] base;
    input [7:0] neg;
    input [7:0] pos;
    reg [39:0] lhs;
    reg [39:0] lim_n;
    reg [39:0] lim_p;
    begin
      lhs = run * 40'd100;
      lim_n = base * (40'd100 - neg);
      lim_p = base * (40'd100 + pos * 40'd10);
      f_guard[0] = (pos != 8'h00) && (lhs > lim_p);
      f_guard[1] = (neg != 8'h00) && (lhs < lim_n);
    end
  endfunction

  // write strobe aimed at one register
  function f_wr_hit;
    input we;
    input [3:0] addr;
    input [3:0] target;
    begin
      f_wr_hit = we && (addr == target);
    end
  endfunction

  // setup byte limited to its largest legal code
  function [7:0] f_clamp;
    input [7:0] value;
    input [7:0] limit;
    begin
      f_clamp = (value > limit) ? limit : value;
    end
  endfunction

  // window reference outside the safe middle band: bit0 high, bit1 low
  function [1:0] f_bound;
    input [7:0] r;
    begin
      f_bound = {r < `KRS_BOUND_LO, r > `KRS_BOUND_HI};
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  reg [7:0] ref_q [0:NUM_KEYS-1];
  reg [CAP_W-1:0] ncz_q [0:NUM_KEYS-1];
  reg [7:0] ofs_q [0:NUM_KEYS-1];
  reg [23:0] absref_q [0:NUM_KEYS-1];
  reg [8:0] dev_q [0:NUM_KEYS-1];
  reg [4:0] cal_q [0:NUM_KEYS-1];
  reg [1:0] err_q [0:NUM_KEYS-1];
  reg [NUM_KEYS-1:0] supp_en_q;
  reg [NUM_KEYS-1:0] armed_q;
  reg [15:0] capc_q;
  reg [7:0] ladc_q;
  reg [7:0] neg_gb_q;
  reg [7:0] pos_gb_q;
  reg [7:0] scope_q;
  reg locked_q;
  reg lock_busy_q;
  reg [KEY_W-1:0] lock_idx_q;
  reg setup_dirty_q;
  reg boot_q;
  reg [NUM_KEYS-1:0] any_cal;
  reg [NUM_KEYS-1:0] any_err;
  reg suppress;
  reg [7:0] new_ref;
  reg [1:0] new_err;
  reg [8:0] new_dev;
  reg [7:0] rd_d;
  integer i;
  integer j;

  wire [KEY_W-1:0] bk = burst_key_i;
  wire [KEY_W-1:0] sk = scope_q[KEY_W-1:0];

  // ************************************************************
  // command decode
  // ************************************************************
  wire ctrl_wr = f_wr_hit(reg_wr_i, reg_addr_i, `KRS_A_CTRL);
  wire cal_cmd = ctrl_wr && reg_wdata_i[`KRS_CTRL_RECAL];
  wire srst_cmd = ctrl_wr && reg_wdata_i[`KRS_CTRL_SRST];
  wire lock_cmd = ctrl_wr && reg_wdata_i[`KRS_CTRL_LOCK];
  wire supp_wr = f_wr_hit(reg_wr_i, reg_addr_i, `KRS_A_SUPP_EN);
  wire setup_wr = supp_wr || f_wr_hit(reg_wr_i, reg_addr_i, `KRS_A_CAPC_HI) ||
                  f_wr_hit(reg_wr_i, reg_addr_i, `KRS_A_CAPC_LO) ||
                  f_wr_hit(reg_wr_i, reg_addr_i, `KRS_A_LADC) ||
                  f_wr_hit(reg_wr_i, reg_addr_i, `KRS_A_NEG_GB) ||
                  f_wr_hit(reg_wr_i, reg_addr_i, `KRS_A_POS_GB);

  // ************************************************************
  // per-burst evaluation of the bursting key
  // ************************************************************
  always @* begin
    new_dev = {1'b0, ref_q[bk]} - {1'b0, burst_signal_i};
    suppress = 1'b0;
    for (i = 0; i < NUM_KEYS; i = i + 1) begin
      any_cal[i] = cal_q[i] != 5'd0;
      any_err[i] = err_q[i] != 2'b00;
      if (supp_en_q[bk] && supp_en_q[i] && i != bk &&
          $signed(dev_q[i]) > $signed(new_dev)) begin
        suppress = 1'b1;
      end
    end
    new_ref = ref_q[bk];
    if (cal_q[bk] == 5'd1) begin
      new_ref = burst_signal_i;
    end else if (cal_q[bk] == 5'd0) begin
      if (fast_recal_i) begin
        new_ref = burst_signal_i;
      end else if (drift_step_i[0] && ref_q[bk] != 8'hFF) begin
        new_ref = ref_q[bk] + 8'h01;
      end else if (drift_step_i[1] && ref_q[bk] != 8'h00) begin
        new_ref = ref_q[bk] - 8'h01;
      end
    end
    new_err = 2'b00;
    if (cal_q[bk] == 5'd0) begin
      new_err = f_bound(new_ref);
      if (locked_q && armed_q[bk]) begin
        new_err = new_err | f_guard(f_abs(capc_q, ladc_q, ncz_q[bk], ofs_q[bk], new_ref),
                                    absref_q[bk], neg_gb_q, pos_gb_q);
      end
    end
  end

  // ************************************************************
  // per-key arrays
  // ************************************************************
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      for (j = 0; j < NUM_KEYS; j = j + 1) begin
        cal_q[j] <= `KRS_FULL_CAL_BURSTS;
        err_q[j] <= 2'b00;
        dev_q[j] <= 9'h000;
        ref_q[j] <= `KRS_RST_REF;
        ncz_q[j] <= {CAP_W{1'b0}};
        ofs_q[j] <= `KRS_RST_REF;
      end
      armed_q <= {NUM_KEYS{1'b0}};
      supp_en_q <= {NUM_KEYS{1'b0}};
      key_detect_o <= {NUM_KEYS{1'b0}};
    end else begin
      if (burst_done_i) begin
        dev_q[bk] <= new_dev;
        ref_q[bk] <= new_ref;
        err_q[bk] <= new_err;
        key_detect_o[bk] <= burst_detect_i && !suppress && cal_q[bk] == 5'd0;
        if (cal_q[bk] != 5'd0) begin
          cal_q[bk] <= cal_q[bk] - 5'd1;
          // coarse steps on capacitors first, then ladder offset trims
          if (cal_q[bk] > `KRS_CAL_COARSE_END) begin
            if (burst_signal_i > `KRS_RST_REF && ncz_q[bk] != {CAP_W{1'b1}}) begin
              ncz_q[bk] <= ncz_q[bk] + 1'b1;
            end
          end else if (burst_signal_i > `KRS_RST_REF && ofs_q[bk] != 8'hFF) begin
            ofs_q[bk] <= ofs_q[bk] + 8'h01;
          end else if (burst_signal_i < `KRS_RST_REF && ofs_q[bk] != 8'h00) begin
            ofs_q[bk] <= ofs_q[bk] - 8'h01;
          end
          if (cal_q[bk] == 5'd1) begin
            armed_q[bk] <= locked_q;
          end
        end
      end
      for (j = 0; j < NUM_KEYS; j = j + 1) begin
        if (srst_cmd || (cal_cmd && (scope_q[`KRS_SCOPE_ALL] || j == sk))) begin
          cal_q[j] <= `KRS_FULL_CAL_BURSTS;
          if (cal_q[j] == 5'd0) begin
            ncz_q[j] <= {CAP_W{1'b0}};
            ofs_q[j] <= `KRS_RST_REF;
          end
          err_q[j] <= 2'b00;
          key_detect_o[j] <= 1'b0;
        end
      end
      if (lock_cmd) begin
        armed_q <= {NUM_KEYS{1'b0}};
      end
      if (supp_wr) begin
        supp_en_q[sk] <= reg_wdata_i[0];
      end
    end
  end

  // lock walk: one key per cycle into the nonvolatile copy
  // nonvolatile copy has no reset: it must survive every reset
  always @(posedge ref_clk_i) begin
    if (lock_busy_q) begin
      absref_q[lock_idx_q] <= f_abs(capc_q, ladc_q, ncz_q[lock_idx_q],
                                    ofs_q[lock_idx_q], ref_q[lock_idx_q]);
    end
  end

  // ************************************************************
  // setup registers
  // ************************************************************
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      capc_q <= `KRS_RST_CAPC;
      ladc_q <= `KRS_RST_LADC;
      neg_gb_q <= `KRS_RST_GB;
      pos_gb_q <= `KRS_RST_GB;
      scope_q <= `KRS_RST_SCOPE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `KRS_A_SCOPE: scope_q <= reg_wdata_i;
        `KRS_A_CAPC_HI: capc_q[15:8] <= reg_wdata_i;
        `KRS_A_CAPC_LO: capc_q[7:0] <= reg_wdata_i;
        `KRS_A_LADC: ladc_q <= reg_wdata_i;
        `KRS_A_NEG_GB: neg_gb_q <= f_clamp(reg_wdata_i, `KRS_NEG_GB_MAX);
        `KRS_A_POS_GB: pos_gb_q <= f_clamp(reg_wdata_i, `KRS_POS_GB_MAX);
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // lock walk control
  // ************************************************************
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      locked_q <= 1'b0;
      lock_busy_q <= 1'b0;
      lock_idx_q <= {KEY_W{1'b0}};
    end else if (lock_cmd && !lock_busy_q) begin
      lock_busy_q <= 1'b1;
      lock_idx_q <= {KEY_W{1'b0}};
    end else if (lock_busy_q) begin
      lock_idx_q <= lock_idx_q + 1'b1;
      if (lock_idx_q == NUM_KEYS - 1) begin
        lock_busy_q <= 1'b0;
        locked_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // boot backup control
  // ************************************************************
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      setup_dirty_q <= 1'b0;
      boot_q <= 1'b1;
      backup_copy_o <= 1'b0;
      backup_restore_o <= 1'b0;
    end else begin
      backup_copy_o <= boot_q && setup_valid_i;
      backup_restore_o <= boot_q && !setup_valid_i;
      boot_q <= srst_cmd;
      if (boot_q) begin
        setup_dirty_q <= 1'b0;
      end
      if (setup_wr) begin
        setup_dirty_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // read port and scan lookup
  // ************************************************************
  always @* begin
    rd_d = 8'h00;
    case (reg_addr_i)
      `KRS_A_SCOPE: rd_d = scope_q;
      `KRS_A_CAPC_HI: rd_d = capc_q[15:8];
      `KRS_A_CAPC_LO: rd_d = capc_q[7:0];
      `KRS_A_LADC: rd_d = ladc_q;
      `KRS_A_NEG_GB: rd_d = neg_gb_q;
      `KRS_A_POS_GB: rd_d = pos_gb_q;
      `KRS_A_STATUS: begin
        rd_d[`KRS_ST_DETECT] = |key_detect_o;
        rd_d[`KRS_ST_CAL] = |any_cal || lock_busy_q;
        rd_d[`KRS_ST_ERR] = |any_err;
        rd_d[`KRS_ST_LOCKED] = locked_q;
        rd_d[`KRS_ST_SETUP] = backup_differs_i || setup_dirty_q;
      end
      `KRS_A_KEY_ERR: begin
        rd_d[`KRS_ERR_HIGH] = err_q[sk][0];
        rd_d[`KRS_ERR_LOW] = err_q[sk][1];
      end
      `KRS_A_SUPP_EN: rd_d = {7'h00, supp_en_q[sk]};
      `KRS_A_ERR_MAP: rd_d = any_err[{sk[KEY_W-1:3], 3'b000} +: 8];
      `KRS_A_REF: rd_d = ref_q[sk];
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
      cancel_cap_count_o <= {CAP_W{1'b0}};
      ladder_offset_o <= 8'h00;
    end else begin
      // zero outside the slot after a read strobe
      reg_rdata_o <= reg_rd_i ? rd_d : 8'h00;
      cancel_cap_count_o <= ncz_q[scan_key_i];
      ladder_offset_o <= ofs_q[scan_key_i];
    end
  end

endmodule

// *** bench/krs_front_model.sv ***
module krs_front_model (
  input wire logic ref_clk_i,
  output logic burst_done_o,
  output logic [5:0] burst_key_o,
  output logic [7:0] burst_signal_o,
  output logic burst_detect_o,
  output logic fast_recal_o,
  output logic [5:0] scan_key_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] walk_q = 10'h000;
  initial {burst_done_o, burst_key_o, burst_signal_o, burst_detect_o, fast_recal_o} = 17'h00000;
  // lookup key moves slowly so offsets can settle between moves
  always @(posedge ref_clk_i) walk_q <= walk_q + 10'h001;
  assign scan_key_o = walk_q[9:4];
  // ************************************************************
  // burst delivery, qualifiers scrambled between bursts
  // ************************************************************
  task automatic put(input logic [5:0] k, input logic [7:0] s, input logic d, input logic f);
    {burst_done_o, burst_key_o, burst_signal_o, burst_detect_o, fast_recal_o} <= {1'b1, k, s, d, f};
    @(posedge ref_clk_i);
  endtask
  task automatic idle();
    {burst_done_o, burst_key_o, burst_signal_o} <= {1'b0, ~burst_key_o, ~burst_signal_o};
    {burst_detect_o, fast_recal_o} <= {~burst_detect_o, ~fast_recal_o};
    @(posedge ref_clk_i);
  endtask
  task automatic burst(input logic [5:0] k, input logic [7:0] s, input logic d, input logic f);
    put(k, s, d, f);
    idle();
  endtask
  task automatic sweep(input int rounds, input logic [7:0] s);
    for (int r = 0; r < rounds; r++) begin
      for (int k = 0; k < 64; k++) put(k[5:0], s, 1'b0, 1'b0);
    end
    idle();
  endtask
endmodule

// *** bench/krs_key_reference_supervisor_chk.sv ***
module krs_key_reference_supervisor_chk #(
  parameter NUM_KEYS = 64,
  parameter KEY_W = 6
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic burst_done_i,
  input wire logic [KEY_W-1:0] scan_key_i,
  input wire logic [7:0] ladder_offset_o,
  input wire logic [NUM_KEYS-1:0] key_detect_o,
  input wire logic setup_valid_i,
  input wire logic backup_copy_o,
  input wire logic backup_restore_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // ************************************************************
  // port relations
  // ************************************************************
  AST_RDATA_SLOT: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its slot");
  AST_UNMAPPED: assert property ($past(reg_rd_i) && $past(reg_addr_i) >= 4'hC |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_KEY_ERR_FIELD: assert property ($past(reg_rd_i) && $past(reg_addr_i) == 4'h8 |-> (reg_rdata_o & 8'hF3) == 8'h00)
    else $error("key error byte has stray bits");
  AST_BOOT_BACKUP: assert property ($rose(rstn_i) |=> backup_copy_o == $past(setup_valid_i) && backup_restore_o == !$past(setup_valid_i))
    else $error("boot backup action wrong");
  AST_BACKUP_EXCL: assert property (!(backup_copy_o && backup_restore_o))
    else $error("copy and restore together");
  AST_BACKUP_PULSE: assert property (backup_copy_o || backup_restore_o |=> !backup_copy_o && !backup_restore_o)
    else $error("backup pulse too long");
  AST_CAL_QUIET: assert property ($rose(rstn_i) |-> (key_detect_o == {NUM_KEYS{1'b0}}) [*8])
    else $error("detect during boot calibration");
  AST_DETECT_CAUSE: assert property ($changed(key_detect_o) |-> $past(burst_done_i) || $past(reg_wr_i))
    else $error("detect changed without burst");
  AST_OFFSET_STEADY: assert property ($changed(ladder_offset_o) && $past(rstn_i, 3) |-> $past(burst_done_i) || $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(scan_key_i) != $past(scan_key_i, 2))
    else $error("offset moved on its own");
endmodule

// *** bench/krs_key_reference_supervisor_tb_top.sv ***
module krs_key_reference_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic setup_valid_i = 1'b1;
  logic backup_differs_i = 1'b0;
  logic burst_done_i, burst_detect_i, fast_recal_i, backup_copy_o, backup_restore_o;
  logic [5:0] burst_key_i, scan_key_i;
  logic [7:0] burst_signal_i, ladder_offset_o, reg_rdata_o;
  logic [3:0] cancel_cap_count_o;
  logic [63:0] key_detect_o;
  int n_fail = 0;
  int n_checks = 0;
  logic [7:0] bs [4] = '{8'hC0, 8'hBF, 8'h3F, 8'h40};
  logic [7:0] be [4] = '{8'h04, 8'h00, 8'h08, 8'h00};
  logic [3:0] ra [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
  logic [7:0] rv [6] = '{8'h80, 8'h05, 8'hE9, 8'h08, 8'h00, 8'h00};
  always #12.5 ref_clk_i = ~ref_clk_i;
  krs_key_reference_supervisor dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .burst_done_i(burst_done_i), .burst_key_i(burst_key_i),
    .burst_signal_i(burst_signal_i), .burst_detect_i(burst_detect_i),
    .fast_recal_i(fast_recal_i), .drift_step_i(2'b00), .scan_key_i(scan_key_i),
    .cancel_cap_count_o(cancel_cap_count_o), .ladder_offset_o(ladder_offset_o),
    .key_detect_o(key_detect_o), .setup_valid_i(setup_valid_i),
    .backup_differs_i(backup_differs_i), .backup_copy_o(backup_copy_o),
    .backup_restore_o(backup_restore_o)
  );
  krs_front_model u_fm (
    .ref_clk_i(ref_clk_i), .burst_done_o(burst_done_i), .burst_key_o(burst_key_i),
    .burst_signal_o(burst_signal_i), .burst_detect_o(burst_detect_i),
    .fast_recal_o(fast_recal_i), .scan_key_o(scan_key_i)
  );
  // ************************************************************
  // bus tasks, compare and verdict
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    {reg_wr_i, reg_wdata_i} <= {1'b0, ~d};
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    chk($sformatf("reg %h", a), exp, reg_rdata_o & m);
    @(posedge ref_clk_i);
  endtask
  task automatic boot(input logic v);
    setup_valid_i <= v;
    rstn_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("backup copy", {7'h00, v}, {7'h00, backup_copy_o});
    chk("backup restore", {7'h00, ~v}, {7'h00, backup_restore_o});
    @(posedge ref_clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    conclude();
  end
  initial begin
    boot(1'b1);
    foreach (ra[i]) rd(ra[i], 8'hFF, rv[i]);
    for (int a = 12; a < 16; a++) rd(a[3:0], 8'hFF, 8'h00);
    rd(4'h7, 8'h12, 8'h02);
    backup_differs_i <= 1'b1;
    rd(4'h7, 8'h10, 8'h10);
    backup_differs_i <= 1'b0;
    rd(4'h7, 8'h10, 8'h00);
    // boot, soft reset and all-key command each need 26 bursts per key
    for (int t = 0; t < 3; t++) begin
      if (t > 0) wr(4'h0, (t == 1) ? 8'h04 : 8'h01);
      u_fm.sweep(25, 8'h80);
      rd(4'h7, 8'h02, 8'h02);
      u_fm.sweep(1, 8'h80);
      rd(4'h7, 8'h02, 8'h00);
    end
    chk("cap count", 8'h00, {4'h0, cancel_cap_count_o});
    chk("ladder offset", 8'h80, ladder_offset_o);
    wr(4'h1, 8'h01);
    wr(4'h9, 8'h01);
    wr(4'h1, 8'h02);
    wr(4'h9, 8'h01);
    u_fm.burst(6'h01, 8'h60, 1'b1, 1'b0);
    u_fm.burst(6'h02, 8'h50, 1'b1, 1'b0);
    u_fm.burst(6'h01, 8'h60, 1'b1, 1'b0);
    u_fm.burst(6'h03, 8'h40, 1'b1, 1'b0);
    u_fm.burst(6'h02, 8'h50, 1'b1, 1'b0);
    chk("detect 1", 8'h00, {7'h00, key_detect_o[1]});
    chk("detect 2", 8'h01, {7'h00, key_detect_o[2]});
    chk("detect 3", 8'h01, {7'h00, key_detect_o[3]});
    wr(4'h1, 8'h05);
    rd(4'h9, 8'h01, 8'h00);
    rd(4'hB, 8'hFF, 8'h80);
    foreach (bs[i]) begin
      u_fm.burst(6'h05, bs[i], 1'b0, 1'b1);
      rd(4'h8, 8'hFF, be[i]);
      rd(4'hB, 8'hFF, bs[i]);
      rd(4'hA, 8'h20, (be[i] == 8'h00) ? 8'h00 : 8'h20);
      rd(4'h7, 8'h06, (be[i] == 8'h00) ? 8'h00 : 8'h04);
    end
    wr(4'h5, 8'h64);
    rd(4'h5, 8'hFF, 8'h63);
    wr(4'h6, 8'hFF);
    rd(4'h6, 8'hFF, 8'h64);
    rd(4'h7, 8'h10, 8'h10);
    wr(4'h5, 8'h01);
    wr(4'h6, 8'h00);
    wr(4'h0, 8'h02);
    repeat (66) @(posedge ref_clk_i);
    rd(4'h7, 8'h08, 8'h08);
    wr(4'h1, 8'h07);
    u_fm.burst(6'h07, 8'h41, 1'b0, 1'b1);
    rd(4'h8, 8'hFF, 8'h00);
    wr(4'h0, 8'h01);
    repeat (26) u_fm.burst(6'h07, 8'h80, 1'b0, 1'b0);
    rd(4'h8, 8'hFF, 8'h00);
    u_fm.burst(6'h07, 8'h41, 1'b0, 1'b1);
    rd(4'h8, 8'hFF, 8'h08);
    rd(4'hA, 8'h80, 8'h80);
    rd(4'h7, 8'h02, 8'h00);
    wr(4'h5, 8'h63);
    u_fm.burst(6'h07, 8'h41, 1'b0, 1'b1);
    rd(4'h8, 8'hFF, 8'h00);
    boot(1'b0);
    rd(4'h7, 8'h08, 8'h00);
    conclude();
  end
endmodule
bind krs_key_reference_supervisor krs_key_reference_supervisor_chk #(
  .NUM_KEYS(NUM_KEYS), .KEY_W(KEY_W)
) u_chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .burst_done_i(burst_done_i),
  .scan_key_i(scan_key_i), .ladder_offset_o(ladder_offset_o), .key_detect_o(key_detect_o),
  .setup_valid_i(setup_valid_i), .backup_copy_o(backup_copy_o),
  .backup_restore_o(backup_restore_o)
);
